// ### hw/fade_seq_pkg.sv
/*
  Constants and types for the LED fade / shutdown sequencer.
  Assumes a 20 MHz system clock and a nominal 32 kHz PWM clock.
*/
package fade_seq_pkg;

  // ==========================================================
  // clocking and timing
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  localparam int unsigned PWM_NOM_HZ = 32_768;
  // internal oscillator divider, one tick per PWM clock period
  localparam int unsigned INT_CLK_DIV = SYS_CLK_HZ / PWM_NOM_HZ;
  // one sixteenth of a second, counted in PWM clock periods
  localparam int unsigned SIXTEENTH_S_TICKS = PWM_NOM_HZ / 16;
  localparam logic [7:0] WAKE_TICKS = 8'h81;
  localparam logic [2:0] DAC_FULL = 3'h7;
  localparam int unsigned DAC_STEPS = 8;

  // ==========================================================
  // bus
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h20;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_CONFIG = 8'h10;
  localparam logic [7:0] REG_FADE_OUT_TIMING = 8'h11;
  localparam logic [7:0] REG_FADE_IN_TIMING = 8'h12;
  localparam logic [7:0] REG_CURRENT_LIMIT = 8'h13;

  // ==========================================================
  // configuration fields
  localparam int unsigned CFG_RUN = 0;
  localparam int unsigned CFG_WAKE_EN = 1;
  localparam int unsigned CFG_RAMP_EN = 2;
  localparam int unsigned CFG_ST_HOLD = 3;
  localparam int unsigned CFG_ST_FADE = 4;
  localparam int unsigned CFG_ST_UP = 5;
  localparam int unsigned CFG_RESET_ALL = 6;
  localparam int unsigned CFG_CLK_SEL = 7;
  // timing fields
  localparam int unsigned FADE_SEL_LSB = 0;
  localparam int unsigned HOLD_SEL_LSB = 3;
  localparam int unsigned UP_SEL_LSB = 0;

  // reset values
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [2:0] LIMIT_RST = 3'h7;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_HOLD = 3'h1,
    ST_FADE = 3'h3,
    ST_OFF = 3'h2,
    ST_UP = 3'h6
  } seq_state_t;

  typedef enum logic [2:0] {
    BP_IDLE = 3'h0,
    BP_ADDR = 3'h1,
    BP_PTR = 3'h3,
    BP_WR = 3'h2,
    BP_RD = 3'h6
  } bus_phase_t;

  typedef struct packed {
    logic ramp_up;
    logic fade_off;
    logic hold_off;
  } seq_status_t;

endpackage : fade_seq_pkg

// ### hw/fade_seq.sv
/*
  Fade / shutdown sequencer with its two-wire slave register port.
  Assumes an open-drain SDA wire resolved outside, SCL driven by the
  master, and an external PWM clock that may stop when not selected.
*/
`timescale 1ns/1ps
`default_nettype none

// How it works
// - fade field bits 2..0 pick instant or 1/16s up to 4s ramp-down.
// - hold field bits 5..3 pick zero or 1/16s up to 4s delay.
// - ramp-up field bits 2..0 pick instant or 1/16s up to 4s.
// - shutdown holds full current, then fades, then switches off.
// - config shows hold-off, fade-off and ramp-up status read-only.
// - a config bit enables ramp-up; disabled means instant full current.
// - one write clearing run starts the whole shutdown sequence.
// - all timing counts ticks of the selected PWM clock.
// - the internal oscillator always runs during fades.
// - ramp drives a 3-bit DAC scaling every output alike.
// - current limit caps the ramp on the way down and up.
// - reset-pin rise then 128-129 quiet ticks triggers wake.
// - wake sets run bit 0, leaves shutdown, starts ramp-up.
// - a reset-pin high pulse shorter than the timeout is ignored.
// - an acknowledged address cancels wake, clears bit 1, run stays low.
// - config bit 7 picks internal oscillator or external clock.
// - frames are start, address+rw, pointer (writes only), data bytes, stop.
// - SDA is open-drain in and out; SCL is only an input.
// - config 0x10 bit 0 clear shuts down, set runs.
// - reset pin low ignores the bus and aborts any frame.
module fade_seq #(
  parameter int unsigned BASE_TICKS = fade_seq_pkg::SIXTEENTH_S_TICKS,
  parameter logic [6:0] SLAVE_ADDR = fade_seq_pkg::SLAVE_ADDR_DEF
) (
  // system
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // pins from outside
  input wire logic I_EXT_PWM_CLK,
  input wire logic I_RST_PIN_N,
  // two-wire bus
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  // current reference and shutdown
  output logic [2:0] O_DAC_LEVEL,
  output logic O_SHUTDOWN,
  output var fade_seq_pkg::seq_status_t O_STATUS
);
  import fade_seq_pkg::*;

  // ========================================================
  // helpers
  function automatic logic [17:0] sel_ticks(input logic [2:0] sel,
                                            input logic [17:0] base);
    sel_ticks = (sel == 3'h0) ? 18'h00000 : (base << (sel - 3'h1));
  endfunction : sel_ticks

  function automatic logic [2:0] cap(input logic [2:0] lvl,
                                     input logic [2:0] lim);
    cap = (lvl < lim) ? lvl : lim;
  endfunction : cap

  localparam logic [17:0] BASE18 = BASE_TICKS[17:0];
  localparam logic [9:0] DIV_LAST = 10'(INT_CLK_DIV - 1);

  // ========================================================
  // registers and wires
  logic run_q, wake_en_q, ramp_en_q, rst_all_q, clk_sel_q;
  logic [7:0] fade_out_q, fade_in_q;
  logic [2:0] limit_q;
  seq_state_t state_q, down_entry;
  logic [17:0] tcnt_q;
  logic [2:0] level_q;
  logic [9:0] div_q;
  logic int_tick_q, pwm_tick;
  logic ext_tgl_q, ext_s1_q, ext_s2_q, ext_s3_q;
  logic rp1_q, rp2_q, rp3_q;
  logic scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  bus_phase_t phase_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q, ptr_q, rd_data;
  logic sda_oe_q, rw_q, mnack_q;
  logic wr_en, addr_ack;
  logic wake_arm_q, wake_fire;
  logic [7:0] wake_cnt_q;
  logic [2:0] hold_sel, fade_sel, up_sel;
  logic [17:0] hold_ticks, fade_step, up_step;

  // ========================================================
  // PWM clock sources
  // external clock domain: a toggle marks each period
  always_ff @(posedge I_EXT_PWM_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ext_tgl_q <= 1'b0;
    end else begin
      ext_tgl_q <= ~ext_tgl_q;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_tgl_q;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // internal oscillator free-runs, fades never wait on it to start
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      div_q <= 10'h000;
      int_tick_q <= 1'b0;
    end else begin
      int_tick_q <= (div_q == DIV_LAST);
      div_q <= (div_q == DIV_LAST) ? 10'h000 : div_q + 10'h001;
    end
  end

  assign pwm_tick = clk_sel_q ? (ext_s2_q ^ ext_s3_q) : int_tick_q;

  // ========================================================
  // pin synchronisers
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      {rp1_q, rp2_q, rp3_q} <= 3'h0;
      {scl1_q, scl2_q, scl3_q} <= 3'h7;
      {sda1_q, sda2_q, sda3_q} <= 3'h7;
    end else begin
      {rp1_q, rp2_q, rp3_q} <= {I_RST_PIN_N, rp1_q, rp2_q};
      {scl1_q, scl2_q, scl3_q} <= {I_SCL, scl1_q, scl2_q};
      {sda1_q, sda2_q, sda3_q} <= {I_SDA, sda1_q, sda2_q};
    end
  end

  assign scl_rise = scl2_q & ~scl3_q;
  assign scl_fall = ~scl2_q & scl3_q;
  assign start_cond = scl2_q & scl3_q & ~sda2_q & sda3_q;
  assign stop_cond = scl2_q & scl3_q & sda2_q & ~sda3_q;

  // ========================================================
  // two-wire slave
  assign addr_ack = scl_fall && bitcnt_q == 4'h8 && phase_q == BP_ADDR
                    && shift_q[7:1] == SLAVE_ADDR;
  assign wr_en = scl_fall && bitcnt_q == 4'h8 && phase_q == BP_WR;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      phase_q <= BP_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      sda_oe_q <= 1'b0;
      rw_q <= 1'b0;
      mnack_q <= 1'b0;
    end else if (!rp2_q || stop_cond) begin
      phase_q <= BP_IDLE;
      sda_oe_q <= 1'b0;
      bitcnt_q <= 4'h0;
    end else if (start_cond) begin
      phase_q <= BP_ADDR;
      sda_oe_q <= 1'b0;
      bitcnt_q <= 4'h0;
    end else if (phase_q != BP_IDLE && scl_rise) begin
      if (bitcnt_q < 4'h8) begin
        shift_q <= {shift_q[6:0], (phase_q == BP_RD) ? 1'b0 : sda2_q};
        bitcnt_q <= bitcnt_q + 4'h1;
      end else if (bitcnt_q == 4'h9) begin
        mnack_q <= sda2_q;
      end
    end else if (phase_q != BP_IDLE && scl_fall) begin
      case (bitcnt_q)
        4'h8: begin
          bitcnt_q <= 4'h9;
          case (phase_q)
            BP_ADDR: begin
              sda_oe_q <= addr_ack;
              rw_q <= shift_q[0];
              if (!addr_ack) begin
                phase_q <= BP_IDLE;
              end
            end
            BP_RD: sda_oe_q <= 1'b0;
            default: sda_oe_q <= 1'b1;
          endcase
        end
        4'h9: begin
          bitcnt_q <= 4'h0;
          case (phase_q)
            BP_ADDR: begin
              phase_q <= rw_q ? BP_RD : BP_PTR;
              shift_q <= rd_data;
              sda_oe_q <= rw_q & ~rd_data[7];
            end
            BP_PTR: begin
              phase_q <= BP_WR;
              sda_oe_q <= 1'b0;
            end
            BP_RD: begin
              phase_q <= mnack_q ? BP_IDLE : BP_RD;
              shift_q <= rd_data;
              sda_oe_q <= ~mnack_q & ~rd_data[7];
            end
            default: sda_oe_q <= 1'b0;
          endcase
        end
        default: begin
          sda_oe_q <= (phase_q == BP_RD) & ~shift_q[7];
        end
      endcase
    end
  end

  // register pointer, no auto-increment
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ptr_q <= 8'h00;
    end else if (scl_fall && bitcnt_q == 4'h8 && phase_q == BP_PTR) begin
      ptr_q <= shift_q;
    end
  end

  // ========================================================
  // register file
  always_comb begin
    case (ptr_q)
      REG_CONFIG: rd_data = {clk_sel_q, rst_all_q, O_STATUS.ramp_up,
                             O_STATUS.fade_off, O_STATUS.hold_off,
                             ramp_en_q, wake_en_q, run_q};
      REG_FADE_OUT_TIMING: rd_data = fade_out_q;
      REG_FADE_IN_TIMING: rd_data = fade_in_q;
      REG_CURRENT_LIMIT: rd_data = {5'h00, limit_q};
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      fade_out_q <= TIMING_RST;
      fade_in_q <= TIMING_RST;
      limit_q <= LIMIT_RST;
      ramp_en_q <= CONFIG_RST[CFG_RAMP_EN];
      rst_all_q <= CONFIG_RST[CFG_RESET_ALL];
      clk_sel_q <= CONFIG_RST[CFG_CLK_SEL];
    end else if (wr_en) begin
      case (ptr_q)
        REG_FADE_OUT_TIMING: fade_out_q <= shift_q;
        REG_FADE_IN_TIMING: fade_in_q <= shift_q;
        REG_CURRENT_LIMIT: limit_q <= shift_q[2:0];
        REG_CONFIG: begin
          ramp_en_q <= shift_q[CFG_RAMP_EN];
          rst_all_q <= shift_q[CFG_RESET_ALL];
          clk_sel_q <= shift_q[CFG_CLK_SEL];
        end
        default: ;
      endcase
    end
  end

  // run and wake enable: hardware set or clear wins over a write
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      run_q <= CONFIG_RST[CFG_RUN];
      wake_en_q <= CONFIG_RST[CFG_WAKE_EN];
    end else begin
      if (wake_fire) begin
        run_q <= 1'b1;
      end else if (wr_en && ptr_q == REG_CONFIG) begin
        run_q <= shift_q[CFG_RUN];
      end
      if (wake_arm_q && addr_ack) begin
        wake_en_q <= 1'b0;
      end else if (wr_en && ptr_q == REG_CONFIG) begin
        wake_en_q <= shift_q[CFG_WAKE_EN];
      end
    end
  end

  // ========================================================
  // wake on reset-pin release
  assign wake_fire = wake_arm_q && pwm_tick
                     && wake_cnt_q == WAKE_TICKS - 8'h01;

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wake_arm_q <= 1'b0;
      wake_cnt_q <= 8'h00;
    end else if (rp2_q && !rp3_q && wake_en_q) begin
      wake_arm_q <= 1'b1;
      wake_cnt_q <= 8'h00;
    end else if (!rp2_q || addr_ack || wake_fire) begin
      wake_arm_q <= 1'b0;
    end else if (wake_arm_q && pwm_tick) begin
      wake_cnt_q <= wake_cnt_q + 8'h01;
    end
  end

  // ========================================================
  // sequencer
  assign hold_sel = fade_out_q[HOLD_SEL_LSB +: 3];
  assign fade_sel = fade_out_q[FADE_SEL_LSB +: 3];
  assign up_sel = fade_in_q[UP_SEL_LSB +: 3];
  assign hold_ticks = sel_ticks(hold_sel, BASE18);
  // each of the eight DAC levels lasts one eighth of the time
  assign fade_step = sel_ticks(fade_sel, BASE18) >> 3;
  assign up_step = sel_ticks(up_sel, BASE18) >> 3;

  always_comb begin
    if (hold_sel != 3'h0) begin
      down_entry = ST_HOLD;
    end else if (fade_sel != 3'h0) begin
      down_entry = ST_FADE;
    end else begin
      down_entry = ST_OFF;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= ST_OFF;
      tcnt_q <= 18'h00000;
      level_q <= 3'h0;
    end else begin
      case (state_q)
        ST_RUN, ST_UP: begin
          if (!run_q) begin
            state_q <= down_entry;
            tcnt_q <= 18'h00000;
            level_q <= (down_entry == ST_OFF) ? 3'h0 : DAC_FULL;
          end else if (state_q == ST_UP && pwm_tick) begin
            if (tcnt_q >= up_step - 18'h00001) begin
              tcnt_q <= 18'h00000;
              if (level_q == DAC_FULL) begin
                state_q <= ST_RUN;
              end else begin
                level_q <= level_q + 3'h1;
              end
            end else begin
              tcnt_q <= tcnt_q + 18'h00001;
            end
          end
        end
        ST_HOLD: begin
          if (run_q) begin
            state_q <= ST_RUN;
          end else if (pwm_tick) begin
            if (tcnt_q >= hold_ticks - 18'h00001) begin
              tcnt_q <= 18'h00000;
              state_q <= (fade_sel != 3'h0) ? ST_FADE : ST_OFF;
              level_q <= (fade_sel != 3'h0) ? DAC_FULL : 3'h0;
            end else begin
              tcnt_q <= tcnt_q + 18'h00001;
            end
          end
        end
        ST_FADE: begin
          if (run_q) begin
            state_q <= ST_RUN;
            level_q <= DAC_FULL;
          end else if (pwm_tick) begin
            if (tcnt_q >= fade_step - 18'h00001) begin
              tcnt_q <= 18'h00000;
              if (level_q == 3'h0) begin
                state_q <= ST_OFF;
              end else begin
                level_q <= level_q - 3'h1;
              end
            end else begin
              tcnt_q <= tcnt_q + 18'h00001;
            end
          end
        end
        ST_OFF: begin
          if (run_q) begin
            tcnt_q <= 18'h00000;
            if (ramp_en_q && up_sel != 3'h0) begin
              state_q <= ST_UP;
              level_q <= 3'h0;
            end else begin
              state_q <= ST_RUN;
              level_q <= DAC_FULL;
            end
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // ========================================================
  // outputs
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_DAC_LEVEL <= 3'h0;
      O_SHUTDOWN <= 1'b1;
      O_STATUS <= '0;
    end else begin
      // limit caps both directions of the ramp
      O_DAC_LEVEL <= cap(level_q, limit_q);
      O_SHUTDOWN <= (state_q == ST_OFF);
      O_STATUS.hold_off <= (state_q == ST_HOLD);
      O_STATUS.fade_off <= (state_q == ST_FADE);
      O_STATUS.ramp_up <= (state_q == ST_UP);
    end
  end

  // open drain: only ever pull low, SCL is never driven
  assign O_SDA = 1'b0;
  assign O_SDA_OE = sda_oe_q;

  // ========================================================
  // checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);

  dac_cap_a: assert property (O_DAC_LEVEL <= $past(limit_q))
    else $error("dac level above current limit");
  hold_full_a: assert property (state_q == ST_HOLD |=>
      O_DAC_LEVEL == cap(DAC_FULL, $past(limit_q)))
    else $error("current not full during hold-off");
  run_clear_a: assert property (state_q == ST_RUN && !run_q
      && hold_sel != 3'h0 |=> state_q == ST_HOLD)
    else $error("clearing run did not start hold-off");
  no_ramp_a: assert property (state_q == ST_OFF && run_q
      && !ramp_en_q |=> state_q == ST_RUN ##1 O_DAC_LEVEL == limit_q)
    else $error("ramp disabled yet not instant full current");
  off_shut_a: assert property (state_q == ST_OFF |=> O_SHUTDOWN)
    else $error("off state without shutdown");
  status_show_a: assert property ($rose(state_q == ST_FADE)
      |=> O_STATUS.fade_off && !O_STATUS.hold_off)
    else $error("fade status wrong");
  sda_idle_a: assert property (phase_q == BP_IDLE && $past(phase_q)
      == BP_IDLE |-> !O_SDA_OE)
    else $error("sda driven while idle");
  pin_abort_a: assert property (!rp2_q |=> phase_q == BP_IDLE
      && !O_SDA_OE)
    else $error("bus not aborted by reset pin");
  wake_run_a: assert property (wake_fire |=> run_q)
    else $error("wake did not set run");
  wake_cancel_a: assert property (wake_arm_q && addr_ack
      |=> !wake_en_q && !wake_arm_q)
    else $error("ack did not cancel wake");
  short_pulse_a: assert property (wake_arm_q && !rp2_q
      |=> !wake_arm_q ##1 !wake_fire)
    else $error("short reset pulse not ignored");

endmodule : fade_seq

`default_nettype wire

// ### tb/fade_host_model.sv
/*
  Two-wire bus master model that drives the sequencer's register port.
  Assumes the bench resolves SDA as an open-drain wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module fade_host_model #(
  parameter logic [6:0] ADDR = 7'h20
) (
  // clock the bit timing is counted in
  input wire logic i_clk,
  // bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // ==========================================
  // bit timing: five system cycles a phase
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic hp;
    repeat (5) @(posedge i_clk);
    #1;
  endtask : hp

  task automatic start;
    o_sda_low = 1'b1;
    hp();
    o_scl = 1'b0;
    hp();
  endtask : start

  task automatic stop;
    o_sda_low = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_low = 1'b0;
    hp();
  endtask : stop

  // fifteen cycles a bit, far above the slowest legal bus clock
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    hp();
    o_scl = 1'b1;
    hp();
    r = i_sda;
    o_scl = 1'b0;
    hp();
  endtask : bit_io

  // byte out MSB first, ninth bit released for the answer
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : xfer

  task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    xfer({ADDR, 1'b0}, rx, a0);
    xfer(p, rx, a1);
    xfer(d, rx, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] rx;
    logic a;
    start();
    xfer({ADDR, 1'b0}, rx, a);
    xfer(p, rx, a);
    stop();
    start();
    xfer({ADDR, 1'b1}, rx, a);
    xfer(8'hFF, d, a);
    stop();
  endtask : read_reg

  task automatic probe(output logic ok);
    logic [7:0] rx;
    start();
    xfer({ADDR, 1'b0}, rx, ok);
    stop();
  endtask : probe
endmodule : fade_host_model
`default_nettype wire

// ### tb/fade_seq_tb.sv
/*
  Self-checking bench for the fade sequencer.
  Assumes fade_host_model on the bus and a short ramp base count.
*/
`timescale 1ns/1ps
`default_nettype none
module fade_seq_tb;
  import fade_seq_pkg::*;
  localparam int BASE = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_clk = 1'b0;
  logic ext_on = 1'b1;
  logic pin_n = 1'b1;
  logic scl, sda_low, sda_w, o_sda, sda_oe, shut, ok;
  logic [2:0] dac, stv, prev_st, prev_dac;
  logic [7:0] rd;
  seq_status_t st;
  int fail_count = 0;
  int comparisons = 0;
  int ticks = 0;
  int cycles = 0;
  int t0;
  int t_rise [3];
  int n_step [3];

  always #25 clk = ~clk;
  assign sda_w = ~(sda_low | (sda_oe & ~o_sda));
  assign stv = st;

  fade_seq #(.BASE_TICKS(BASE)) DUT (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_EXT_PWM_CLK(ext_clk),
    .I_RST_PIN_N(pin_n), .I_SCL(scl), .I_SDA(sda_w), .O_SDA(o_sda),
    .O_SDA_OE(sda_oe), .O_DAC_LEVEL(dac), .O_SHUTDOWN(shut),
    .O_STATUS(st));

  fade_host_model HOST (.i_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_low(sda_low));

  // ==========================================
  // external PWM clock: one 3 ns pulse every four cycles
  always begin
    repeat (4) @(posedge clk);
    if (ext_on) begin
      #17 ext_clk = 1'b1;
      #3 ext_clk = 1'b0;
      ticks++;
    end
  end

  // phase start tick and DAC steps of each status bit
  always @(posedge clk) begin
    #2;
    for (int b = 0; b < 3; b++) begin
      if (stv[b] === 1'b1 && prev_st[b] !== 1'b1) begin
        t_rise[b] = ticks;
        n_step[b] = 0;
      end else if (stv[b] === 1'b1 && dac !== prev_dac) begin
        n_step[b]++;
      end
    end
    prev_st = stv;
    prev_dac = dac;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ==========================================
  // tasks
  task automatic wrap_up;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic near(input int got, input int exp, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : near

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    HOST.write_reg(p, d, ok);
    chk({7'h00, ok}, 8'h01);
  endtask : wr

  task automatic rdc(input logic [7:0] p, input logic [7:0] exp);
    HOST.read_reg(p, rd);
    chk(rd, exp);
  endtask : rdc

  // wait out one status phase, then check its ticks and steps
  task automatic phase(input int b, input int len, input int steps);
    int n;
    n = 0;
    while (stv[b] !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    while (stv[b] === 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    #2;
    near(ticks - t_rise[b], len, 3);
    near(n_step[b], steps, 1);
  endtask : phase

  // ==========================================
  // tests
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(4);
    chk({1'b0, stv, shut, dac}, 8'h08);
    rdc(REG_CONFIG, 8'h00);
    rdc(REG_FADE_OUT_TIMING, 8'h00);
    rdc(REG_FADE_IN_TIMING, 8'h00);
    rdc(REG_CURRENT_LIMIT, 8'h07);
    HOST.write_reg(8'h20, 8'hAA, ok);
    rdc(8'h20, 8'h00);
    wr(REG_CONFIG, 8'h78);
    rdc(REG_CONFIG, 8'h40);
    pin_n = 1'b0;
    cyc(4);
    HOST.write_reg(REG_FADE_OUT_TIMING, 8'h55, ok);
    chk({7'h00, ok}, 8'h00);
    pin_n = 1'b1;
    cyc(4);
    rdc(REG_FADE_OUT_TIMING, 8'h00);
    for (int n = 1; n < 8; n++) begin
      wr(REG_FADE_OUT_TIMING, 8'(n * 9));
      wr(REG_FADE_IN_TIMING, 8'(n));
      wr(REG_CONFIG, 8'h85);
      phase(2, BASE << (n - 1), 7);
      chk({4'h0, shut, dac}, 8'h07);
      wr(REG_CONFIG, 8'h84);
      phase(0, BASE << (n - 1), 0);
      phase(1, BASE << (n - 1), 7);
      cyc(2);
      chk({4'h0, shut, dac}, 8'h08);
    end
    wr(REG_FADE_OUT_TIMING, 8'h09);
    wr(REG_FADE_IN_TIMING, 8'h01);
    wr(REG_CURRENT_LIMIT, 8'h03);
    wr(REG_CONFIG, 8'h85);
    phase(2, BASE, 3);
    chk({4'h0, shut, dac}, 8'h03);
    wr(REG_CONFIG, 8'h84);
    phase(0, BASE, 0);
    phase(1, BASE, 3);
    wr(REG_CURRENT_LIMIT, 8'h07);
    wr(REG_FADE_OUT_TIMING, 8'h00);
    wr(REG_FADE_IN_TIMING, 8'h07);
    wr(REG_CONFIG, 8'h81);
    chk({1'b0, stv, shut, dac}, 8'h07);
    wr(REG_CONFIG, 8'h80);
    chk({1'b0, stv, shut, dac}, 8'h08);
    ext_on = 1'b0;
    wr(REG_FADE_IN_TIMING, 8'h01);
    wr(REG_CONFIG, 8'h05);
    t0 = cycles;
    rdc(REG_CONFIG, 8'h25);
    while (stv[2] === 1'b1 && cycles - t0 < 20000) cyc(1);
    near(cycles - t0, BASE * int'(INT_CLK_DIV), 1300);
    ext_on = 1'b1;
    wr(REG_CONFIG, 8'h86);
    rdc(REG_CONFIG, 8'h86);
    pin_n = 1'b0;
    cyc(10);
    pin_n = 1'b1;
    t0 = ticks;
    phase(2, BASE, 7);
    near(t_rise[2] - t0, 129, 3);
    rdc(REG_CONFIG, 8'h87);
    wr(REG_CONFIG, 8'h86);
    pin_n = 1'b0;
    cyc(10);
    pin_n = 1'b1;
    cyc(240);
    pin_n = 1'b0;
    cyc(800);
    chk({4'h0, shut, dac}, 8'h08);
    pin_n = 1'b1;
    cyc(20);
    HOST.probe(ok);
    chk({7'h00, ok}, 8'h01);
    cyc(800);
    chk({4'h0, shut, dac}, 8'h08);
    rdc(REG_CONFIG, 8'h84);
    chk({7'h00, o_sda}, 8'h00);
    wrap_up();
  end
endmodule : fade_seq_tb
`default_nettype wire
